// ===== rtl/rmul_pkg.sv
`default_nettype none
// ==========================================================
// Shared constants and carriers of the registered multiplier
package rmul_pkg;
    localparam int          OP_W        = 16;
    localparam int          AXI_AW      = 4;
    // Register byte offsets
    localparam logic [3:0]  CTRL_OFF    = 4'h0;
    localparam logic [3:0]  PROD_OFF    = 4'h4;
    // Control field: 1 selects separate load clocks, 0 single clock with enables
    localparam int          CTRL_SEP_B  = 0;
    localparam logic        CTRL_RST    = 1'b0;
    // Round weights below the upper half, plain and shifted formats
    localparam logic [31:0] ROUND_FULL  = 32'h0000_8000;
    localparam logic [31:0] ROUND_SHIFT = 32'h0000_4000;
    localparam logic [15:0] HALF_RST    = 16'h0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // Operand register: mode bit and 16 data bits
    typedef struct packed {
        logic              mode;
        logic [OP_W-1:0]   val;
    } rmul_operand_t;
    // Both product halves
    typedef struct packed {
        logic [OP_W-1:0]   upper;
        logic [OP_W-1:0]   lower;
    } rmul_product_t;
endpackage
`default_nettype wire

// ===== rtl/rmul_top.sv
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
// How it works
// - The two registered 16-bit operands are multiplied into a full 32-bit product.
// - Each operand register is 17 bits: 16 data bits plus that operand's mode bit.
// - Each operand is signed or unsigned by its own registered mode bit.
// - A mixed signed and unsigned pair gives a two's complement product.
// - Format adjust picks the full product or the one-bit left-shifted 31-bit form.
// - Two 16-bit registers hold upper and lower product halves split per format adjust.
// - Feedthrough high makes both product registers transparent.
// - Round request rounds the upper half and is registered with either operand load.
// - A multiplexer puts either product half on the 16-bit three-state product port.
// - The lower half can drive the Y bus through its own three-state buffer.
// - In the separate clock mode X, Y, upper and lower registers load on their own clocks.
// - In the single clock mode three enables gate X, Y and both product registers.
// - All registers capture on the rising edge in both modes.
module rmul_top (
    input  wire logic                       clock_i,
    input  wire logic                       reset_i,
    // Operands and controls
    input  wire logic [15:0]                x_data_i,
    input  wire logic                       x_mode_i,
    input  wire logic [15:0]                y_bus_i,
    input  wire logic                       y_mode_i,
    input  wire logic                       format_adjust_i,
    input  wire logic                       round_request_i,
    input  wire logic                       output_feedthrough_i,
    input  wire logic                       product_half_select_i,
    input  wire logic                       product_drive_i,
    input  wire logic                       y_bus_drive_i,
    // Separate load clocks and single clock enables
    input  wire logic                       x_register_clock_i,
    input  wire logic                       y_register_clock_i,
    input  wire logic                       upper_half_clock_i,
    input  wire logic                       lower_half_clock_i,
    input  wire logic                       x_register_enable_i,
    input  wire logic                       y_register_enable_i,
    input  wire logic                       product_register_enable_i,
    // Product port and Y bus driver
    output logic [15:0]                     product_o,
    output logic                            product_oe_o,
    output logic [15:0]                     y_bus_o,
    output logic                            y_bus_oe_o,
    // AXI4-Lite slave
    input  wire logic [rmul_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [rmul_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready
);
    // ==========================================================
    // Load clock synchronisers
    logic [3:0]              sync1_q;
    logic [3:0]              sync2_q;
    logic [3:0]              sync3_q;
    logic [3:0]              edge_w;

    // Three stages; the edge detector reads only the last two
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
        end
        else
        begin
            sync1_q <= {lower_half_clock_i, upper_half_clock_i,
                        y_register_clock_i, x_register_clock_i};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign edge_w = sync2_q & ~sync3_q;

    // ==========================================================
    // Load decode
    logic sep_mode_q;
    logic load_x;
    logic load_y;
    logic load_u;
    logic load_l;

    // Rising edges of separate clocks, or enables on the one clock
    always_comb
    begin
        if (sep_mode_q)
        begin
            load_x = edge_w[0];
            load_y = edge_w[1];
            load_u = edge_w[2];
            load_l = edge_w[3];
        end
        else
        begin
            load_x = x_register_enable_i;
            load_y = y_register_enable_i;
            load_u = product_register_enable_i;
            load_l = product_register_enable_i;
        end
    end

    // ==========================================================
    // Multiplier array
    rmul_pkg::rmul_operand_t x_q;
    rmul_pkg::rmul_operand_t x_d;
    rmul_pkg::rmul_operand_t y_q;
    rmul_pkg::rmul_operand_t y_d;
    rmul_pkg::rmul_product_t prod_q;
    rmul_pkg::rmul_product_t prod_d;
    rmul_pkg::rmul_product_t array_w;
    logic                    round_q;
    logic                    round_d;
    logic signed [16:0]      x_ext;
    logic signed [16:0]      y_ext;
    logic signed [33:0]      full_w;
    logic [31:0]             raw_w;
    logic [31:0]             rounded_w;

    // Sign or zero extension per operand mode
    assign x_ext  = {x_q.mode & x_q.val[15], x_q.val};
    assign y_ext  = {y_q.mode & y_q.val[15], y_q.val};
    assign full_w = x_ext * y_ext;
    assign raw_w  = format_adjust_i ? {full_w[30:0], 1'b0} : full_w[31:0];
    assign rounded_w = raw_w + (round_q ? (format_adjust_i ? rmul_pkg::ROUND_SHIFT << 1
                                                          : rmul_pkg::ROUND_FULL)
                                        : 32'h0000_0000);

    // Upper half rounded, lower half straight from the array
    always_comb
    begin
        array_w.upper = rounded_w[31:16];
        array_w.lower = raw_w[15:0];
    end

    // Next operand, round and product register values
    always_comb
    begin
        x_d     = load_x ? {x_mode_i, x_data_i} : x_q;
        y_d     = load_y ? {y_mode_i, y_bus_i} : y_q;
        round_d = (load_x | load_y) ? round_request_i : round_q;
        prod_d.upper = load_u ? array_w.upper : prod_q.upper;
        prod_d.lower = load_l ? array_w.lower : prod_q.lower;
    end

    // Datapath registers, rising edge
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            x_q     <= '0;
            y_q     <= '0;
            round_q <= 1'b0;
            prod_q  <= {rmul_pkg::HALF_RST, rmul_pkg::HALF_RST};
        end
        else
        begin
            x_q     <= x_d;
            y_q     <= y_d;
            round_q <= round_d;
            prod_q  <= prod_d;
        end
    end

    // ==========================================================
    // Output multiplexer and three-state drivers
    rmul_pkg::rmul_product_t out_w;

    // Transparent registers while feedthrough is high
    assign out_w        = output_feedthrough_i ? array_w : prod_q;
    assign product_o    = product_half_select_i ? out_w.lower : out_w.upper;
    assign product_oe_o = product_drive_i;
    assign y_bus_o      = out_w.lower;
    assign y_bus_oe_o   = y_bus_drive_i;

    // ==========================================================
    // AXI4-Lite slave
    logic                     aw_full_q;
    logic                     aw_full_d;
    logic                     w_full_q;
    logic                     w_full_d;
    logic [rmul_pkg::AXI_AW-1:0] awaddr_q;
    logic [rmul_pkg::AXI_AW-1:0] awaddr_d;
    logic [31:0]              wdata_q;
    logic [31:0]              wdata_d;
    logic                     wstrb0_q;
    logic                     wstrb0_d;
    logic                     bvalid_d;
    logic [1:0]               bresp_d;
    logic                     rvalid_d;
    logic [1:0]               rresp_d;
    logic [31:0]              rdata_d;
    logic                     sep_mode_d;

    assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_full_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    // Write capture in either order, response once both held
    always_comb
    begin
        aw_full_d  = aw_full_q | (s_axi_awvalid & s_axi_awready);
        w_full_d   = w_full_q | (s_axi_wvalid & s_axi_wready);
        awaddr_d   = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_q;
        wdata_d    = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_q;
        wstrb0_d   = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb[0] : wstrb0_q;
        bvalid_d   = s_axi_bvalid & ~s_axi_bready;
        bresp_d    = s_axi_bresp;
        sep_mode_d = sep_mode_q;
        if (aw_full_q & w_full_q)
        begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = rmul_pkg::RESP_OKAY;
            if (awaddr_q == rmul_pkg::CTRL_OFF)
            begin
                if (wstrb0_q)
                    sep_mode_d = wdata_q[rmul_pkg::CTRL_SEP_B];
            end
            else if (awaddr_q != rmul_pkg::PROD_OFF)
                bresp_d = rmul_pkg::RESP_SLVERR;
        end
        // Read answer one cycle after the address is taken
        rvalid_d = s_axi_rvalid & ~s_axi_rready;
        rdata_d  = s_axi_rdata;
        rresp_d  = s_axi_rresp;
        if (s_axi_arvalid & s_axi_arready)
        begin
            rvalid_d = 1'b1;
            rresp_d  = rmul_pkg::RESP_OKAY;
            rdata_d  = 32'h0000_0000;
            case (s_axi_araddr)
                rmul_pkg::CTRL_OFF: rdata_d[rmul_pkg::CTRL_SEP_B] = sep_mode_q;
                rmul_pkg::PROD_OFF: rdata_d = prod_q;
                default:            rresp_d = rmul_pkg::RESP_SLVERR;
            endcase
        end
    end

    // Bus state registers
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            awaddr_q     <= '0;
            wdata_q      <= 32'h0000_0000;
            wstrb0_q     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= rmul_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= rmul_pkg::RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            sep_mode_q   <= rmul_pkg::CTRL_RST;
        end
        else
        begin
            aw_full_q    <= aw_full_d;
            w_full_q     <= w_full_d;
            awaddr_q     <= awaddr_d;
            wdata_q      <= wdata_d;
            wstrb0_q     <= wstrb0_d;
            s_axi_bvalid <= bvalid_d;
            s_axi_bresp  <= bresp_d;
            s_axi_rvalid <= rvalid_d;
            s_axi_rresp  <= rresp_d;
            s_axi_rdata  <= rdata_d;
            sep_mode_q   <= sep_mode_d;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    a_operand_capture: assert property (load_x |=> x_q == $past({x_mode_i, x_data_i}))
        else $error("X operand register missed its load");
    a_unsigned_product: assert property ((!x_q.mode && !y_q.mode)
        |-> full_w[31:0] == 32'(x_q.val) * 32'(y_q.val))
        else $error("Unsigned product wrong");
    a_mixed_sign: assert property ((x_q.mode && x_q.val[15]
        && !y_q.mode && y_q.val != 16'h0000) |-> full_w[31])
        else $error("Mixed product not negative");
    a_shift_format: assert property ((load_u && format_adjust_i && !round_q)
        |=> prod_q.upper == $past(full_w[30:15]))
        else $error("Shifted upper half wrong");
    a_feedthrough_path: assert property (output_feedthrough_i
        && !product_half_select_i |-> product_o == rounded_w[31:16])
        else $error("Feedthrough not transparent");
    a_round_capture: assert property ((load_x || load_y)
        |=> round_q == $past(round_request_i))
        else $error("Round bit not captured");
    a_round_weight: assert property ((round_q && !format_adjust_i
            && load_u && load_l)
        |=> prod_q.upper == $past(16'((full_w[31:0] + 32'h0000_8000) >> 16))
            && prod_q.lower == $past(full_w[15:0]))
        else $error("Rounding applied wrongly");
    a_port_select: assert property (!output_feedthrough_i
        && product_half_select_i |-> product_o == prod_q.lower)
        else $error("Product port select wrong");
    a_y_buffer: assert property (!output_feedthrough_i
        |-> y_bus_o == prod_q.lower && y_bus_oe_o == y_bus_drive_i)
        else $error("Y bus driver wrong");
    a_sep_clock: assert property ((sep_mode_q && sync2_q[2] && !sync3_q[2])
        |=> prod_q.upper == $past(array_w.upper))
        else $error("Upper clock edge did not load");

endmodule // rmul_top
`default_nettype wire

// ===== testbench/rmul_ybus_model.sv
`default_nettype none
// ==========================================================
// Controller side of the shared Y operand bus
module rmul_ybus_model (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic [15:0] ctl_val_i,
    input  wire logic        ctl_drive_i,
    input  wire logic [15:0] dev_val_i,
    input  wire logic        dev_drive_i,
    output logic      [15:0] level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] last_q;
    // Floating bus toggles so a stale value never reads as valid
    always_ff @(posedge clock_i or posedge reset_i)
        if (reset_i) last_q <= 16'h0000;
        else last_q <= level_o;
    // Bus level from whichever side drives it
    always_comb
    begin
        if (dev_drive_i) level_o = dev_val_i;
        else if (ctl_drive_i) level_o = ctl_val_i;
        else level_o = ~last_q;
    end
endmodule // rmul_ybus_model
`default_nettype wire

// ===== testbench/tb_top.sv
`default_nettype none
// ==========================================================
// Self-checking bench of the registered multiplier
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i, reset_i, x_mode, y_mode, fmt, round_req, thru, sel, pdrv, ydrv;
    logic        y_ctl_drive;
    logic [3:0]  lclk;
    logic        x_en, y_en, p_en, chk, product_oe, y_bus_oe;
    logic [15:0] x_data, y_ctl_val, y_level, product_o, y_bus_o;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [33:0] rcur;
    int          error_cnt, checks_done;
    rmul_pkg::rmul_product_t pq[$];
    rmul_pkg::rmul_product_t cur;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];

    rmul_top u_rmul_top (.clock_i(clock_i), .reset_i(reset_i), .x_data_i(x_data),
        .x_mode_i(x_mode), .y_bus_i(y_level), .y_mode_i(y_mode), .format_adjust_i(fmt),
        .round_request_i(round_req), .output_feedthrough_i(thru), .product_half_select_i(sel),
        .product_drive_i(pdrv), .y_bus_drive_i(ydrv), .x_register_clock_i(lclk[0]),
        .y_register_clock_i(lclk[1]), .upper_half_clock_i(lclk[2]), .lower_half_clock_i(lclk[3]),
        .x_register_enable_i(x_en), .y_register_enable_i(y_en),
        .product_register_enable_i(p_en), .product_o(product_o), .product_oe_o(product_oe),
        .y_bus_o(y_bus_o), .y_bus_oe_o(y_bus_oe), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    rmul_ybus_model u_rmul_ybus_model (.clock_i(clock_i), .reset_i(reset_i),
        .ctl_val_i(y_ctl_val), .ctl_drive_i(y_ctl_drive), .dev_val_i(y_bus_o),
        .dev_drive_i(y_bus_oe), .level_o(y_level));

    // Clock at 25 MHz
    initial
    begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // Compare and count
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Verdict and end of run
    task automatic results();
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Wait limit used up
    task automatic hang(input string name);
        error_cnt++;
        $display("MISMATCH %s expected answer seen none", name);
        results();
    endtask

    // Reference product from operand values and modes
    function automatic rmul_pkg::rmul_product_t model(input logic [15:0] x, input logic [15:0] y,
        input logic xm, input logic ym, input logic f, input logic r);
        logic signed [33:0] a, b;
        logic [31:0]        q, u;
        a = {{18{xm & x[15]}}, x};
        b = {{18{ym & y[15]}}, y};
        q = 32'(a * b);
        if (f) q = q << 1;
        u = q + (r ? 32'h0000_8000 : 32'h0000_0000);
        model = {u[31:16], q[15:0]};
    endfunction

    // AXI write, response noted for the monitor
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] rsp);
        int n;
        n = 0;
        bq.push_back(rsp);
        @(posedge clock_i);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do
        begin
            @(posedge clock_i);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 100);
        bready <= 1'b0;
        if (n >= 100) hang("s_axi_bvalid");
    endtask

    // AXI read, data and response noted for the monitor
    task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] rsp);
        int n;
        n = 0;
        rq.push_back({rsp, d});
        @(posedge clock_i);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do
        begin
            @(posedge clock_i);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        rready <= 1'b0;
        if (n >= 100) hang("s_axi_rvalid");
    endtask

    // One random multiply, through registers or feedthrough, on enables or load clocks
    task automatic op(input logic use_ft, input logic sep);
        rmul_pkg::rmul_product_t e;
        logic [15:0]             xv, yv;
        logic                    xm, ym, f, r, s;
        xv = ($urandom_range(3) == 0) ? 16'h8000 : 16'($urandom);
        yv = ($urandom_range(3) == 0) ? 16'hFFFF : 16'($urandom);
        xm = 1'($urandom);
        ym = 1'($urandom);
        f = xm & ym & 1'($urandom);
        r = 1'($urandom);
        s = 1'($urandom);
        e = model(xv, yv, xm, ym, f, r);
        @(posedge clock_i);
        x_data <= xv;
        y_ctl_val <= yv;
        x_mode <= xm;
        y_mode <= ym;
        fmt <= f;
        round_req <= r;
        thru <= use_ft;
        sel <= s;
        pdrv <= s;
        x_en <= !sep;
        y_en <= !sep;
        y_ctl_drive <= 1'b1;
        lclk <= {2'b00, sep, sep};
        if (sep)
        begin
            // Operands load a few edges on, then both product clocks rise
            repeat (4) @(posedge clock_i);
            lclk <= {sep, sep, 2'b00};
            repeat (4) @(posedge clock_i);
        end
        @(posedge clock_i);
        x_en <= 1'b0;
        y_en <= 1'b0;
        lclk <= 4'h0;
        p_en <= !use_ft && !sep;
        round_req <= !r;
        @(posedge clock_i);
        p_en <= 1'b0;
        y_ctl_drive <= 1'b0;
        ydrv <= 1'b1;
        chk <= 1'b1;
        pq.push_back(e);
        @(posedge clock_i);
        chk <= 1'b0;
        ydrv <= 1'b0;
        if (!use_ft || sep) rd(rmul_pkg::PROD_OFF, e, rmul_pkg::RESP_OKAY);
    endtask

    // Product port and Y bus against the oldest note
    always @(negedge clock_i)
        if (chk)
        begin
            cur = pq.pop_front();
            check("product_o", 32'(sel ? cur.lower : cur.upper), 32'(product_o));
            check("y_bus_o", 32'(cur.lower), 32'(y_bus_o));
            check("product_oe_o", 32'(pdrv), 32'(product_oe));
            check("y_bus_oe_o", 32'(ydrv), 32'(y_bus_oe));
        end

    // Bus answers against the oldest note
    always @(posedge clock_i)
    begin
        if (rvalid && rready)
        begin
            rcur = rq.pop_front();
            check("s_axi_rdata", rcur[31:0], rdata);
            check("s_axi_rresp", 32'(rcur[33:32]), 32'(rresp));
        end
        if (bvalid && bready) check("s_axi_bresp", 32'(bq.pop_front()), 32'(bresp));
    end

    // Main sequence
    initial
    begin
        error_cnt = 0;
        checks_done = 0;
        reset_i = 1'b1;
        chk = 1'b0;
        lclk = 4'h0;
        {x_data, y_ctl_val, x_mode, y_mode, fmt, round_req, thru, sel, pdrv, ydrv} = '0;
        {y_ctl_drive, x_en, y_en, p_en, awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        void'($urandom(47412));
        repeat (8) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        chk <= 1'b1;
        pq.push_back('0);
        @(posedge clock_i);
        chk <= 1'b0;
        rd(rmul_pkg::CTRL_OFF, 32'h0000_0000, rmul_pkg::RESP_OKAY);
        wr(rmul_pkg::CTRL_OFF, 32'h0000_0001, rmul_pkg::RESP_OKAY);
        rd(rmul_pkg::CTRL_OFF, 32'h0000_0001, rmul_pkg::RESP_OKAY);
        wr(rmul_pkg::CTRL_OFF, 32'h0000_0000, rmul_pkg::RESP_OKAY);
        wr(rmul_pkg::PROD_OFF, 32'hFFFF_FFFF, rmul_pkg::RESP_OKAY);
        rd(rmul_pkg::PROD_OFF, 32'h0000_0000, rmul_pkg::RESP_OKAY);
        rd(4'h8, 32'h0000_0000, rmul_pkg::RESP_SLVERR);
        wr(4'hC, 32'h0000_0000, rmul_pkg::RESP_SLVERR);
        repeat (60) op(1'($urandom), 1'b0);
        wr(rmul_pkg::CTRL_OFF, 32'h0000_0001, rmul_pkg::RESP_OKAY);
        repeat (20) op(1'($urandom), 1'b1);
        results();
    end
endmodule // tb_top
`default_nettype wire
